// ==== core/mcrb_pkg.sv ====
package mcrb_pkg;

	// Index-port register offsets
	localparam logic [7:0] MCRB_TX_SUM_CTL  = 8'h31;
	localparam logic [7:0] MCRB_RX_SUM_STAT = 8'h32;
	localparam logic [7:0] MCRB_EXT_PHY_ADR = 8'h33;
	localparam logic [7:0] MCRB_LED_FUNC    = 8'h34;
	localparam logic [7:0] MCRB_BUS_PIN_CTL = 8'h38;
	localparam logic [7:0] MCRB_IRQ_PIN_CTL = 8'h39;
	localparam logic [7:0] MCRB_CLK_STOP    = 8'h50;
	localparam logic [7:0] MCRB_CLK_RESUME  = 8'h51;
	localparam logic [7:0] MCRB_RD_PREFETCH = 8'hF0;
	localparam logic [7:0] MCRB_RD_PLAIN    = 8'hF1;

	// Field positions
	localparam int MCRB_UDP_GEN_BIT   = 2;
	localparam int MCRB_TCP_GEN_BIT   = 1;
	localparam int MCRB_IP_GEN_BIT    = 0;
	localparam int MCRB_UDP_FAIL_BIT  = 7;
	localparam int MCRB_TCP_FAIL_BIT  = 6;
	localparam int MCRB_IP_FAIL_BIT   = 5;
	localparam int MCRB_UDP_SEEN_BIT  = 4;
	localparam int MCRB_TCP_SEEN_BIT  = 3;
	localparam int MCRB_IP_SEEN_BIT   = 2;
	localparam int MCRB_CHECK_EN_BIT  = 1;
	localparam int MCRB_DROP_BAD_BIT  = 0;
	localparam int MCRB_ADR_EN_BIT    = 7;
	localparam int MCRB_LED_GP_BIT    = 1;
	localparam int MCRB_LED_MGMT_BIT  = 0;
	localparam int MCRB_DRIVE_LSB     = 5;
	localparam int MCRB_HYST_BIT      = 3;
	localparam int MCRB_WR_FILT_BIT   = 1;
	localparam int MCRB_RD_FILT_BIT   = 0;
	localparam int MCRB_IRQ_TYPE_BIT  = 1;
	localparam int MCRB_IRQ_POL_BIT   = 0;
	localparam int MCRB_CLK_STOP_BIT  = 0;

	// Writable masks and reset values
	localparam logic [7:0] MCRB_TX_SUM_MASK  = 8'h07;
	localparam logic [7:0] MCRB_RX_SUM_WMASK = 8'h03;
	localparam logic [7:0] MCRB_EXT_PHY_MASK = 8'h9F;
	localparam logic [7:0] MCRB_LED_MASK     = 8'h03;
	localparam logic [7:0] MCRB_IRQ_MASK     = 8'h03;
	localparam logic [7:0] MCRB_BUS_PIN_RST  = 8'h61;
	localparam logic [7:0] MCRB_EXT_PHY_RST  = 8'h01;
	localparam logic [7:0] MCRB_ZERO_BYTE    = 8'h00;

	// Longest strobe pulse that the glitch filter removes, rounded up to whole clock cycles
	localparam int MCRB_CLK_PERIOD_PS = 50000;
	localparam int MCRB_SPIKE_PS      = 2000;
	localparam int MCRB_FILT_CYCLES   = (MCRB_SPIKE_PS + MCRB_CLK_PERIOD_PS - 1)
		/ MCRB_CLK_PERIOD_PS;

endpackage : mcrb_pkg

// ==== core/mcrb_bank.sv ====
`timescale 1ns/100ps
module mcrb_bank #(
	parameter logic [4:0] INT_PHY_ADDR = 5'h01
) (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	// Host index/data port pins
	input  wire logic       host_cs_n_i,
	input  wire logic       host_cmd_i,
	input  wire logic       host_read_strobe_n_i,
	input  wire logic       host_write_strobe_n_i,
	input  wire logic [7:0] host_data_i,
	output logic      [7:0] host_data_o,
	output logic            host_data_oe_o,
	// Pin options
	output logic      [2:0] bus_drive_strength_o,
	output logic            strobe_hysteresis_en_o,
	// Transmit checksum enables
	output logic            udp_sum_gen_en_o,
	output logic            tcp_sum_gen_en_o,
	output logic            ip_sum_gen_en_o,
	// Receive checksum results
	input  wire logic       rx_pkt_done_i,
	input  wire logic       rx_udp_seen_i,
	input  wire logic       rx_tcp_seen_i,
	input  wire logic       rx_ip_seen_i,
	input  wire logic       rx_udp_bad_i,
	input  wire logic       rx_tcp_bad_i,
	input  wire logic       rx_ip_bad_i,
	output logic      [7:0] rx_hdr_status_o,
	output logic            rx_pkt_drop_o,
	// Receive buffer access
	input  wire logic [7:0] rx_buf_data_i,
	output logic            rx_buf_rd_o,
	output logic            rx_buf_prefetch_o,
	// Management frame address
	output logic      [4:0] mgmt_phy_addr_o,
	// Light pins and their sources
	input  wire logic       io_16bit_i,
	input  wire logic       led_a_val_i,
	input  wire logic       led_b_val_i,
	input  wire logic [2:1] gp_dir_i,
	input  wire logic [2:1] gp_out_i,
	input  wire logic       mdio_out_i,
	input  wire logic       mdio_oe_i,
	input  wire logic       mdc_i,
	input  wire logic       status_light_pin_a_i,
	input  wire logic       status_light_pin_b_i,
	output logic            status_light_pin_a_o,
	output logic            status_light_pin_a_oe_o,
	output logic            status_light_pin_b_o,
	output logic            status_light_pin_b_oe_o,
	output logic      [2:1] gp_in_o,
	output logic            mdio_in_o,
	// Interrupt pin
	input  wire logic       irq_req_i,
	output logic            irq_pin_o,
	output logic            irq_pin_oe_o,
	// Clock control
	output logic            sysclk_stop_o,
	output logic            phy_power_down_o
);
	import mcrb_pkg::*;

	logic [7:0] tx_sum_r;
	logic [7:0] rx_stat_r;
	logic [7:0] ext_phy_r;
	logic [7:0] led_func_r;
	logic [7:0] bus_pin_r;
	logic [7:0] irq_ctl_r;
	logic [7:0] index_r;
	logic       clk_stop_r;
	logic [7:0] rd_data_r;
	logic       drop_r;
	logic       buf_rd_r;
	logic       prefetch_r;

	// Two-stage synchronisers on host pins
	logic [11:0] pin_s1_r;
	logic [11:0] pin_s2_r;
	logic [1:0]  led_s1_r;
	logic [1:0]  led_s2_r;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_s1_r <= 12'h0C1;
			pin_s2_r <= 12'h0C1;
			led_s1_r <= 2'h0;
			led_s2_r <= 2'h0;
		end else begin
			pin_s1_r <= {host_data_i, host_cmd_i, ~host_write_strobe_n_i,
				~host_read_strobe_n_i, host_cs_n_i};
			pin_s2_r <= pin_s1_r;
			led_s1_r <= {status_light_pin_b_i, status_light_pin_a_i};
			led_s2_r <= led_s1_r;
		end
	end

	logic       cs_s;
	logic       cmd_s;
	logic [7:0] wdata_s;
	assign cs_s    = ~pin_s2_r[0];
	assign cmd_s   = pin_s2_r[3];
	assign wdata_s = pin_s2_r[11:4];

	// Strobe glitch filters: index 0 read, index 1 write
	logic [1:0] strb_raw;
	logic [1:0] strb_en;
	logic [1:0] strb_filt_r;
	logic [1:0] strb_prev_r;
	logic [1:0] strb_del_r [0:MCRB_FILT_CYCLES-1];
	assign strb_raw = pin_s2_r[2:1];
	assign strb_en  = {bus_pin_r[MCRB_WR_FILT_BIT], bus_pin_r[MCRB_RD_FILT_BIT]};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_filt
			logic stable;
			logic filt_r;
			always_comb begin
				stable = 1'b1;
				for (int k = 0; k < MCRB_FILT_CYCLES; k++) begin
					stable = stable & (strb_del_r[k][g] == strb_raw[g]);
				end
			end
			always_ff @(posedge mclk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					filt_r <= 1'b0;
				end else if (!strb_en[g] || stable) begin
					filt_r <= strb_raw[g];
				end
			end
			assign strb_filt_r[g] = filt_r;
		end
	endgenerate

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int k = 0; k < MCRB_FILT_CYCLES; k++) begin
				strb_del_r[k] <= 2'h0;
			end
			strb_prev_r <= 2'h0;
		end else begin
			strb_del_r[0] <= strb_raw;
			for (int k = 1; k < MCRB_FILT_CYCLES; k++) begin
				strb_del_r[k] <= strb_del_r[k-1];
			end
			strb_prev_r <= strb_filt_r;
		end
	end

	logic rd_start;
	logic wr_start;
	logic idx_wr;
	logic dat_wr;
	logic dat_rd;
	assign rd_start = strb_filt_r[0] & ~strb_prev_r[0] & cs_s;
	assign wr_start = strb_filt_r[1] & ~strb_prev_r[1] & cs_s;
	assign idx_wr   = wr_start & ~cmd_s;
	assign dat_wr   = wr_start & cmd_s;
	assign dat_rd   = rd_start & cmd_s;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			index_r <= MCRB_ZERO_BYTE;
		end else if (idx_wr) begin
			index_r <= wdata_s;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_sum_r   <= MCRB_ZERO_BYTE;
			ext_phy_r  <= MCRB_EXT_PHY_RST;
			led_func_r <= MCRB_ZERO_BYTE;
			bus_pin_r  <= MCRB_BUS_PIN_RST;
			irq_ctl_r  <= MCRB_ZERO_BYTE;
		end else if (dat_wr) begin
			case (index_r)
				MCRB_TX_SUM_CTL:  tx_sum_r   <= wdata_s & MCRB_TX_SUM_MASK;
				MCRB_EXT_PHY_ADR: ext_phy_r  <= wdata_s & MCRB_EXT_PHY_MASK;
				MCRB_LED_FUNC:    led_func_r <= wdata_s & MCRB_LED_MASK;
				MCRB_BUS_PIN_CTL: bus_pin_r  <= wdata_s;
				MCRB_IRQ_PIN_CTL: irq_ctl_r  <= wdata_s & MCRB_IRQ_MASK;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_stat_r <= MCRB_ZERO_BYTE;
		end else begin
			if (rx_pkt_done_i) begin
				rx_stat_r[MCRB_UDP_FAIL_BIT] <= rx_udp_seen_i & rx_udp_bad_i;
				rx_stat_r[MCRB_TCP_FAIL_BIT] <= rx_tcp_seen_i & rx_tcp_bad_i;
				rx_stat_r[MCRB_IP_FAIL_BIT]  <= rx_ip_seen_i & rx_ip_bad_i;
				rx_stat_r[MCRB_UDP_SEEN_BIT] <= rx_udp_seen_i;
				rx_stat_r[MCRB_TCP_SEEN_BIT] <= rx_tcp_seen_i;
				rx_stat_r[MCRB_IP_SEEN_BIT]  <= rx_ip_seen_i;
			end
			if (dat_wr && index_r == MCRB_RX_SUM_STAT) begin
				rx_stat_r[1:0] <= wdata_s[1:0] & MCRB_RX_SUM_WMASK[1:0];
			end
		end
	end

	logic any_bad;
	assign any_bad = (rx_udp_seen_i & rx_udp_bad_i) | (rx_tcp_seen_i & rx_tcp_bad_i)
		| (rx_ip_seen_i & rx_ip_bad_i);

	always_comb begin
		rx_hdr_status_o = MCRB_ZERO_BYTE;
		if (rx_stat_r[MCRB_CHECK_EN_BIT]) begin
			rx_hdr_status_o[7:2] = rx_stat_r[7:2];
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drop_r <= 1'b0;
		end else begin
			drop_r <= rx_pkt_done_i & any_bad & rx_stat_r[MCRB_DROP_BAD_BIT];
		end
	end
	assign rx_pkt_drop_o = drop_r;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clk_stop_r <= 1'b0;
		end else if (idx_wr && wdata_s == MCRB_CLK_RESUME) begin
			clk_stop_r <= 1'b0;
		end else if (dat_wr && index_r == MCRB_CLK_STOP) begin
			clk_stop_r <= wdata_s[MCRB_CLK_STOP_BIT];
		end
	end
	assign sysclk_stop_o    = clk_stop_r;
	assign phy_power_down_o = clk_stop_r;

	// Read data captured at the start of the read strobe
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_r <= MCRB_ZERO_BYTE;
		end else if (rd_start) begin
			if (!cmd_s) begin
				rd_data_r <= index_r;
			end else begin
				case (index_r)
					MCRB_TX_SUM_CTL:  rd_data_r <= tx_sum_r;
					MCRB_RX_SUM_STAT: rd_data_r <= rx_stat_r;
					MCRB_EXT_PHY_ADR: rd_data_r <= ext_phy_r;
					MCRB_LED_FUNC:    rd_data_r <= led_func_r;
					MCRB_BUS_PIN_CTL: rd_data_r <= bus_pin_r;
					MCRB_IRQ_PIN_CTL: rd_data_r <= irq_ctl_r;
					MCRB_RD_PREFETCH: rd_data_r <= rx_buf_data_i;
					MCRB_RD_PLAIN:    rd_data_r <= rx_buf_data_i;
					default:          rd_data_r <= MCRB_ZERO_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			buf_rd_r   <= 1'b0;
			prefetch_r <= 1'b0;
		end else begin
			buf_rd_r   <= dat_rd & (index_r == MCRB_RD_PREFETCH || index_r == MCRB_RD_PLAIN);
			prefetch_r <= dat_rd & (index_r == MCRB_RD_PREFETCH);
		end
	end
	assign rx_buf_rd_o       = buf_rd_r;
	assign rx_buf_prefetch_o = prefetch_r;

	assign host_data_o    = rd_data_r;
	assign host_data_oe_o = strb_filt_r[0] & strb_prev_r[0] & cs_s;

	assign bus_drive_strength_o   = bus_pin_r[MCRB_DRIVE_LSB+:3];
	assign strobe_hysteresis_en_o = bus_pin_r[MCRB_HYST_BIT];
	assign udp_sum_gen_en_o       = tx_sum_r[MCRB_UDP_GEN_BIT];
	assign tcp_sum_gen_en_o       = tx_sum_r[MCRB_TCP_GEN_BIT];
	assign ip_sum_gen_en_o        = tx_sum_r[MCRB_IP_GEN_BIT];

	logic gp_mode;
	logic mgmt_mode;
	assign gp_mode   = io_16bit_i & led_func_r[MCRB_LED_GP_BIT];
	assign mgmt_mode = io_16bit_i & led_func_r[MCRB_LED_MGMT_BIT] & ~gp_mode;

	assign mgmt_phy_addr_o = (ext_phy_r[MCRB_ADR_EN_BIT] && mgmt_mode) ? ext_phy_r[4:0]
		: INT_PHY_ADDR;

	always_comb begin
		status_light_pin_a_o    = led_a_val_i;
		status_light_pin_a_oe_o = 1'b1;
		status_light_pin_b_o    = led_b_val_i;
		status_light_pin_b_oe_o = 1'b1;
		if (gp_mode) begin
			status_light_pin_a_o    = gp_out_i[1];
			status_light_pin_a_oe_o = gp_dir_i[1];
			status_light_pin_b_o    = gp_out_i[2];
			status_light_pin_b_oe_o = gp_dir_i[2];
		end else if (mgmt_mode) begin
			status_light_pin_a_o    = mdio_out_i;
			status_light_pin_a_oe_o = mdio_oe_i;
			status_light_pin_b_o    = mdc_i;
			status_light_pin_b_oe_o = 1'b1;
		end
	end
	assign gp_in_o   = {led_s2_r[1], led_s2_r[0]};
	assign mdio_in_o = led_s2_r[0];

	logic irq_level;
	assign irq_level = irq_ctl_r[MCRB_IRQ_POL_BIT] ? ~irq_req_i : irq_req_i;
	assign irq_pin_o    = irq_ctl_r[MCRB_IRQ_TYPE_BIT] ? 1'b0 : irq_level;
	assign irq_pin_oe_o = irq_ctl_r[MCRB_IRQ_TYPE_BIT] ? ~irq_level : 1'b1;

endmodule : mcrb_bank

// ==== verif/mcrb_bank_checker.sv ====
`timescale 1ns/100ps
module mcrb_bank_checker #(
	parameter logic [4:0] INT_PHY_ADDR = 5'h01
) (
	// Clock and reset
	input wire logic       mclk_i,
	input wire logic       arst_n_i,
	// Receive checksum side
	input wire logic       rx_pkt_done_i,
	input wire logic       rx_udp_seen_i,
	input wire logic       rx_tcp_seen_i,
	input wire logic       rx_ip_seen_i,
	input wire logic       rx_udp_bad_i,
	input wire logic       rx_tcp_bad_i,
	input wire logic       rx_ip_bad_i,
	input wire logic       rx_pkt_drop_o,
	input wire logic       rx_buf_rd_o,
	input wire logic       rx_buf_prefetch_o,
	// Pin and clock controls
	input wire logic [2:0] bus_drive_strength_o,
	input wire logic [4:0] mgmt_phy_addr_o,
	input wire logic       irq_req_i,
	input wire logic       irq_pin_o,
	input wire logic       irq_pin_oe_o,
	input wire logic       sysclk_stop_o,
	input wire logic       phy_power_down_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	logic bad_any;
	assign bad_any = (rx_udp_seen_i & rx_udp_bad_i) | (rx_tcp_seen_i & rx_tcp_bad_i)
		| (rx_ip_seen_i & rx_ip_bad_i);
	property p_drive_rst;
		$rose(arst_n_i) |-> bus_drive_strength_o == 3'b011;
	endproperty
	a_drive_rst: assert property (p_drive_rst) else $error("drive strength not 011");
	property p_irq_rst;
		$rose(arst_n_i) |-> irq_pin_oe_o && (irq_pin_o == irq_req_i);
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq pin not active high");
	property p_addr_rst;
		$rose(arst_n_i) |-> mgmt_phy_addr_o == INT_PHY_ADDR;
	endproperty
	a_addr_rst: assert property (p_addr_rst) else $error("phy address wrong");
	property p_drop_cause;
		rx_pkt_drop_o |-> $past(rx_pkt_done_i) && $past(bad_any);
	endproperty
	a_drop_cause: assert property (p_drop_cause) else $error("drop without cause");
	property p_no_drop;
		rx_pkt_done_i && !bad_any |=> !rx_pkt_drop_o;
	endproperty
	a_no_drop: assert property (p_no_drop) else $error("clean packet dropped");
	property p_stop_pd;
		sysclk_stop_o == phy_power_down_o;
	endproperty
	a_stop_pd: assert property (p_stop_pd) else $error("stop and power down differ");
	property p_pf_rd;
		rx_buf_prefetch_o |-> rx_buf_rd_o;
	endproperty
	a_pf_rd: assert property (p_pf_rd) else $error("prefetch without read");
	property p_rd_pulse;
		rx_buf_rd_o |=> !rx_buf_rd_o [*8];
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("buffer read repeated");
endmodule : mcrb_bank_checker

// ==== verif/mcrb_host_model.sv ====
`timescale 1ns/100ps
module mcrb_host_model (
	// Clock and device read data
	input  wire logic       mclk_i,
	input  wire logic [7:0] rd_data_i,
	// Index/data port pins
	output logic            cs_n_o = 1'b1,
	output logic            cmd_o  = 1'b0,
	output logic            rd_n_o = 1'b1,
	output logic            wr_n_o = 1'b1,
	output logic      [7:0] wd_o   = 8'h00
);
	task automatic xfer(input logic cmd, input logic wr, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		cmd_o <= cmd;
		wd_o <= wd;
		wr_n_o <= !wr;
		rd_n_o <= wr;
		repeat (8) @(posedge mclk_i);
		rd = rd_data_i;
		cs_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		// Released bus shows no stale value
		wd_o <= ~wd;
		repeat (3) @(posedge mclk_i);
	endtask : xfer
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
		logic [7:0] d;
		xfer(1'b0, 1'b1, idx, d);
		xfer(1'b1, 1'b1, val, d);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
		logic [7:0] d;
		xfer(1'b0, 1'b1, idx, d);
		xfer(1'b1, 1'b0, 8'h00, val);
	endtask : rd_reg
	// One-cycle strobe inside a longer chip select
	task automatic spike(input logic cmd, input logic wr, input logic [7:0] wd);
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		cmd_o <= cmd;
		wd_o <= wd;
		@(posedge mclk_i);
		wr_n_o <= !wr;
		rd_n_o <= wr;
		@(posedge mclk_i);
		wr_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		repeat (3) @(posedge mclk_i);
		cs_n_o <= 1'b1;
		wd_o <= ~wd;
		repeat (3) @(posedge mclk_i);
	endtask : spike
endmodule : mcrb_host_model

// ==== verif/misc_control_register_bank_tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module misc_control_register_bank_tb;
	import mcrb_pkg::*;
	typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} mcrb_row_t;
	int num_errors = 0;
	int checked = 0;
	int rd_cnt = 0;
	int pf_cnt = 0;
	int oe_cnt = 0;
	int rd_base = 0;
	logic mclk_i = 1'b0, arst_n_i = 1'b0, io_16bit_i = 1'b1, irq_req_i = 1'b0;
	logic rx_pkt_done_i = 1'b0, rx_udp_seen_i = 1'b0, rx_tcp_seen_i = 1'b0;
	logic rx_ip_seen_i = 1'b0, rx_udp_bad_i = 1'b0, rx_tcp_bad_i = 1'b0, rx_ip_bad_i = 1'b0;
	logic led_a_val_i = 1'b1, led_b_val_i = 1'b0, mdio_out_i = 1'b1, mdio_oe_i = 1'b0;
	logic mdc_i = 1'b1;
	logic [2:1] gp_dir_i = 2'b10, gp_out_i = 2'b01, gp_in_o;
	logic [7:0] rx_buf_data_i = 8'h00, host_data_i, host_data_o, rx_hdr_status_o, v;
	logic host_cs_n_i, host_cmd_i, host_read_strobe_n_i, host_write_strobe_n_i;
	logic host_data_oe_o, strobe_hysteresis_en_o, udp_sum_gen_en_o, tcp_sum_gen_en_o;
	logic ip_sum_gen_en_o, rx_pkt_drop_o, rx_buf_rd_o, rx_buf_prefetch_o, mdio_in_o;
	logic status_light_pin_a_i, status_light_pin_a_o, status_light_pin_a_oe_o;
	logic status_light_pin_b_i, status_light_pin_b_o, status_light_pin_b_oe_o;
	logic irq_pin_o, irq_pin_oe_o, sysclk_stop_o, phy_power_down_o;
	logic [2:0] bus_drive_strength_o;
	logic [4:0] mgmt_phy_addr_o;
	mcrb_row_t rows[8] = '{'{MCRB_TX_SUM_CTL, 8'hFF, 8'h07}, '{MCRB_RX_SUM_STAT, 8'hFF, 8'h03},
		'{MCRB_EXT_PHY_ADR, 8'hFF, 8'h9F}, '{MCRB_LED_FUNC, 8'hFD, 8'h01},
		'{MCRB_BUS_PIN_CTL, 8'h5A, 8'h5A}, '{MCRB_IRQ_PIN_CTL, 8'hFF, 8'h03},
		'{MCRB_CLK_STOP, 8'h00, 8'h00}, '{8'h77, 8'hFF, 8'h00}};
	// Pulled-up light pins
	assign status_light_pin_a_i = status_light_pin_a_oe_o ? status_light_pin_a_o : 1'b1;
	assign status_light_pin_b_i = status_light_pin_b_oe_o ? status_light_pin_b_o : 1'b1;
	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		rd_cnt <= rd_cnt + (rx_buf_rd_o ? 1 : 0);
		pf_cnt <= pf_cnt + (rx_buf_prefetch_o ? 1 : 0);
		oe_cnt <= oe_cnt + (host_data_oe_o ? 1 : 0);
	end
	mcrb_bank #(.INT_PHY_ADDR(5'h01)) i_mcrb_bank (.mclk_i, .arst_n_i, .host_cs_n_i, .host_cmd_i,
		.host_read_strobe_n_i, .host_write_strobe_n_i, .host_data_i, .host_data_o,
		.host_data_oe_o, .bus_drive_strength_o, .strobe_hysteresis_en_o, .udp_sum_gen_en_o,
		.tcp_sum_gen_en_o, .ip_sum_gen_en_o, .rx_pkt_done_i, .rx_udp_seen_i, .rx_tcp_seen_i,
		.rx_ip_seen_i, .rx_udp_bad_i, .rx_tcp_bad_i, .rx_ip_bad_i, .rx_hdr_status_o,
		.rx_pkt_drop_o, .rx_buf_data_i, .rx_buf_rd_o, .rx_buf_prefetch_o, .mgmt_phy_addr_o,
		.io_16bit_i, .led_a_val_i, .led_b_val_i, .gp_dir_i, .gp_out_i, .mdio_out_i, .mdio_oe_i,
		.mdc_i, .status_light_pin_a_i, .status_light_pin_b_i, .status_light_pin_a_o,
		.status_light_pin_a_oe_o, .status_light_pin_b_o, .status_light_pin_b_oe_o, .gp_in_o,
		.mdio_in_o, .irq_req_i, .irq_pin_o, .irq_pin_oe_o, .sysclk_stop_o, .phy_power_down_o);
	mcrb_host_model i_mcrb_host_model (.mclk_i(mclk_i), .rd_data_i(host_data_o),
		.cs_n_o(host_cs_n_i), .cmd_o(host_cmd_i), .rd_n_o(host_read_strobe_n_i),
		.wr_n_o(host_write_strobe_n_i), .wd_o(host_data_i));
	task end_of_test;
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic pkt(input logic [5:0] sb, input logic drop, input logic [7:0] st,
		input logic [7:0] hdr);
		@(posedge mclk_i);
		rx_pkt_done_i <= 1'b1;
		{rx_udp_seen_i, rx_tcp_seen_i, rx_ip_seen_i, rx_udp_bad_i, rx_tcp_bad_i, rx_ip_bad_i} <= sb;
		@(posedge mclk_i);
		rx_pkt_done_i <= 1'b0;
		@(negedge mclk_i);
		`CHK(rx_pkt_drop_o, drop)
		i_mcrb_host_model.rd_reg(MCRB_RX_SUM_STAT, v);
		`CHK(v, st)
		`CHK(rx_hdr_status_o, hdr)
	endtask : pkt
	task automatic buf_rd(input logic [7:0] idx, input logic [7:0] d, input int pf);
		int r0 = rd_cnt;
		int p0 = pf_cnt;
		int o0 = oe_cnt;
		rx_buf_data_i <= d;
		i_mcrb_host_model.rd_reg(idx, v);
		`CHK(v, d)
		`CHK((oe_cnt - o0) > 0, 1'b1)
		`CHK(host_data_oe_o, 1'b0)
		`CHK(rd_cnt - r0, 1)
		`CHK(pf_cnt - p0, pf)
	endtask : buf_rd
	initial begin
		repeat (4) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		foreach (rows[i]) begin
			i_mcrb_host_model.wr_reg(rows[i].idx, rows[i].wd);
			i_mcrb_host_model.rd_reg(rows[i].idx, v);
			`CHK(v, rows[i].exp)
		end
		`CHK({udp_sum_gen_en_o, tcp_sum_gen_en_o, ip_sum_gen_en_o}, 3'b111)
		`CHK(bus_drive_strength_o, 3'b010)
		`CHK(strobe_hysteresis_en_o, 1'b1)
		`CHK(mgmt_phy_addr_o, 5'h1F)
		`CHK({status_light_pin_a_o, status_light_pin_a_oe_o}, {mdio_out_i, mdio_oe_i})
		`CHK({status_light_pin_b_o, status_light_pin_b_oe_o}, {mdc_i, 1'b1})
		`CHK(mdio_in_o, 1'b1)
		irq_req_i <= 1'b1;
		@(negedge mclk_i);
		`CHK({irq_pin_o, irq_pin_oe_o}, 2'b01)
		@(posedge mclk_i) irq_req_i <= 1'b0;
		@(negedge mclk_i);
		`CHK(irq_pin_oe_o, 1'b0)
		i_mcrb_host_model.wr_reg(MCRB_IRQ_PIN_CTL, 8'h01);
		`CHK({irq_pin_o, irq_pin_oe_o}, 2'b11)
		i_mcrb_host_model.wr_reg(MCRB_LED_FUNC, 8'h02);
		`CHK({status_light_pin_a_o, status_light_pin_a_oe_o}, {gp_out_i[1], gp_dir_i[1]})
		`CHK({status_light_pin_b_o, status_light_pin_b_oe_o}, {gp_out_i[2], gp_dir_i[2]})
		`CHK(mgmt_phy_addr_o, 5'h01)
		`CHK(gp_in_o, 2'b01)
		pkt(6'b100100, 1'b1, 8'h93, 8'h90);
		pkt(6'b111000, 1'b0, 8'h1F, 8'h1C);
		pkt(6'b011011, 1'b1, 8'h6F, 8'h6C);
		i_mcrb_host_model.wr_reg(MCRB_RX_SUM_STAT, 8'h00);
		pkt(6'b001001, 1'b0, 8'h24, 8'h00);
		buf_rd(MCRB_RD_PREFETCH, 8'hA5, 1);
		buf_rd(MCRB_RD_PLAIN, 8'h3C, 0);
		i_mcrb_host_model.wr_reg(MCRB_CLK_STOP, 8'h01);
		`CHK({sysclk_stop_o, phy_power_down_o}, 2'b11)
		i_mcrb_host_model.xfer(1'b0, 1'b1, MCRB_CLK_RESUME, v);
		`CHK(sysclk_stop_o, 1'b0)
		arst_n_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		i_mcrb_host_model.rd_reg(MCRB_BUS_PIN_CTL, v);
		`CHK(v, 8'h61)
		`CHK(bus_drive_strength_o, 3'b011)
		`CHK(strobe_hysteresis_en_o, 1'b0)
		`CHK({status_light_pin_a_o, status_light_pin_a_oe_o, status_light_pin_b_o,
			status_light_pin_b_oe_o}, 4'b1101)
		i_mcrb_host_model.rd_reg(MCRB_EXT_PHY_ADR, v);
		`CHK(v, 8'h01)
		i_mcrb_host_model.rd_reg(MCRB_IRQ_PIN_CTL, v);
		`CHK(v, 8'h00)
		// Short write strobe taken while its filter is off
		i_mcrb_host_model.xfer(1'b0, 1'b1, MCRB_TX_SUM_CTL, v);
		i_mcrb_host_model.spike(1'b1, 1'b1, 8'h05);
		i_mcrb_host_model.rd_reg(MCRB_TX_SUM_CTL, v);
		`CHK(v, 8'h05)
		// Both filters on: short strobes ignored
		i_mcrb_host_model.wr_reg(MCRB_BUS_PIN_CTL, 8'h63);
		i_mcrb_host_model.xfer(1'b0, 1'b1, MCRB_TX_SUM_CTL, v);
		i_mcrb_host_model.spike(1'b1, 1'b1, 8'h02);
		i_mcrb_host_model.rd_reg(MCRB_TX_SUM_CTL, v);
		`CHK(v, 8'h05)
		i_mcrb_host_model.xfer(1'b0, 1'b1, MCRB_RD_PLAIN, v);
		rd_base = rd_cnt;
		i_mcrb_host_model.spike(1'b1, 1'b0, 8'h00);
		`CHK(rd_cnt - rd_base, 0)
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		end_of_test();
	end
endmodule : misc_control_register_bank_tb
bind mcrb_bank mcrb_bank_checker #(.INT_PHY_ADDR(INT_PHY_ADDR)) i_mcrb_bank_checker (.mclk_i,
	.arst_n_i, .rx_pkt_done_i, .rx_udp_seen_i, .rx_tcp_seen_i, .rx_ip_seen_i, .rx_udp_bad_i,
	.rx_tcp_bad_i, .rx_ip_bad_i, .rx_pkt_drop_o, .rx_buf_rd_o, .rx_buf_prefetch_o,
	.bus_drive_strength_o, .mgmt_phy_addr_o, .irq_req_i, .irq_pin_o, .irq_pin_oe_o,
	.sysclk_stop_o, .phy_power_down_o);
